// *** verilog/io_input_defines.vh ***
// constants for the input handshake and jump block
// assumes ref_clk at 250 mhz and a four-phase machine cycle of 1.6 us
`ifndef IO_INPUT_DEFINES_VH
`define IO_INPUT_DEFINES_VH
// *****************************
// timing
// *****************************
`define CLK_PERIOD_PS 4000
`define MACHINE_CYCLE_NS 1600
`define ACK_DELAY_NS 2000
`define PHASE_CYCLES (`MACHINE_CYCLE_NS * 1000 / `CLK_PERIOD_PS / 4)
`define ACK_DELAY_CYCLES ((`ACK_DELAY_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CH0_ACK_CYCLES (`MACHINE_CYCLE_NS * 1000 / `CLK_PERIOD_PS)
// *****************************
// instruction codes
// *****************************
`define FUNC_IO 6'h0a
`define FUNC_JUMP 6'h0e
`define DESIG_INPUT 3'h0
`define DESIG_OUTPUT 3'h1
`define DESIG_INTR 3'h2
// *****************************
// phases and fields
// *****************************
`define PHASE_ONE 2'h0
`define PHASE_TWO 2'h1
`define PHASE_THREE 2'h2
`define PHASE_FOUR 2'h3
`define LOW_SIX_WIDTH 6
`define WORD_WIDTH 15
// *****************************
// instruction word fields
// *****************************
`define FUNC_MSB 14
`define FUNC_LSB 9
`define DESIG_MSB 8
`define DESIG_LSB 6
`define OPERAND_MSB 8
`define OPERAND_LSB 0
`define CHAN_SEL_BIT 0
`endif

// *** verilog/line_sync.v ***
// three-stage synchroniser with second/third agreement
// assumes an asynchronous level input and the ref_clk domain
`timescale 1ns/1ps
module line_sync (
  input wire ref_clk,
  input wire srst,
  input wire din,
  output reg dout
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;
  // first stage feeds only the second
  always @(posedge ref_clk) begin
    if (srst) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        dout <= s3_reg;
      end
    end
  end
endmodule

// *** verilog/io_input_handshake.v ***
// input handshake, io jump evaluation and interrupt handling
// assumes instruction strobes from the sequencer on ref_clk; pins are asynchronous
// Contract
// - channel 0 ack about 2 us after load
// - channel 0 ack held until data loaded
// - channel 0 ack lasts one machine cycle
// - channel 1 moves full 15-bit word
// - channel 1 gates at phase four, clears phase two
// - gated ones survive the overlapping clear
// - channel 1 ack held until request and interrupt drop
// - jumps ignore channel, either request counts
// - input jump taken only with no request
// - idle state: input jumps always taken
// - pending request: input jump not taken
// - after ack, jump disabled until request and interrupt drop
// - output jump taken with output ack flag set and no output request
// - interrupt jump taken while interrupt low and input ack flag set
// - lines low: flag set, ack off, jumps enabled
// - input instruction splits function and operand
// - operand bit zero selects channel
// - channel 0 clears and loads low six bits
// - channel 1 clears whole data register
`timescale 1ns/1ps
`include "io_input_defines.vh"
module io_input_handshake #(
  parameter WORD_WIDTH = `WORD_WIDTH,
  parameter LOW_SIX_WIDTH = `LOW_SIX_WIDTH
) (
  input wire ref_clk,
  input wire srst,
  input wire instr_valid,
  input wire [WORD_WIDTH-1:0] instr_word,
  input wire jump_sample,
  input wire [LOW_SIX_WIDTH-1:0] tty_data,
  input wire [WORD_WIDTH-1:0] cable_data,
  input wire ch0_in_req,
  input wire ch1_in_req,
  input wire ch0_out_req,
  input wire ch1_out_req,
  input wire interrupt_line,
  input wire output_ack_flag,
  output wire ch0_in_ack,
  output wire ch1_in_ack,
  output reg [WORD_WIDTH-1:0] in_data,
  output reg jump_flag,
  output reg input_ack_flag,
  output reg [5:0] func_reg,
  output reg [8:0] operand_reg,
  output reg busy
);
  // *****************************
  // synchronised lines
  // *****************************
  wire s_ch0_req;
  wire s_ch1_req;
  wire s_ch0_oreq;
  wire s_ch1_oreq;
  wire s_intr;
  line_sync u_s0 (.ref_clk(ref_clk), .srst(srst), .din(ch0_in_req), .dout(s_ch0_req));
  line_sync u_s1 (.ref_clk(ref_clk), .srst(srst), .din(ch1_in_req), .dout(s_ch1_req));
  line_sync u_s2 (.ref_clk(ref_clk), .srst(srst), .din(ch0_out_req), .dout(s_ch0_oreq));
  line_sync u_s3 (.ref_clk(ref_clk), .srst(srst), .din(ch1_out_req), .dout(s_ch1_oreq));
  line_sync u_s4 (.ref_clk(ref_clk), .srst(srst), .din(interrupt_line), .dout(s_intr));
  // either channel counts; the program must keep only one device active
  wire any_in_req = s_ch0_req | s_ch1_req;
  wire any_out_req = s_ch0_oreq | s_ch1_oreq;
  // data pins take the same three stages; the handshake holds them steady while
  // they are sampled, so per-bit agreement is safe, at a cost of four cycles of lag
  wire [LOW_SIX_WIDTH-1:0] s_tty_data;
  wire [WORD_WIDTH-1:0] s_cable_data;
  genvar gi;
  generate
    for (gi = 0; gi < LOW_SIX_WIDTH; gi = gi + 1) begin : g_tty_sync
      line_sync u_t (.ref_clk(ref_clk), .srst(srst), .din(tty_data[gi]), .dout(s_tty_data[gi]));
    end
    for (gi = 0; gi < WORD_WIDTH; gi = gi + 1) begin : g_cable_sync
      line_sync u_c (.ref_clk(ref_clk), .srst(srst), .din(cable_data[gi]), .dout(s_cable_data[gi]));
    end
  endgenerate
  // *****************************
  // phase generator
  // *****************************
  localparam PH_W = 8;
  localparam CNT_W = 12;
  reg [PH_W-1:0] ph_cnt_reg;
  reg [1:0] phase_reg;
  wire phase_end = (ph_cnt_reg == (`PHASE_CYCLES - 1));
  always @(posedge ref_clk) begin
    if (srst) begin
      ph_cnt_reg <= {PH_W{1'b0}};
      phase_reg <= `PHASE_ONE;
    end else if (phase_end) begin
      ph_cnt_reg <= {PH_W{1'b0}};
      phase_reg <= phase_reg + 2'h1;
    end else begin
      ph_cnt_reg <= ph_cnt_reg + 1'b1;
    end
  end
  wire enter_phase_two = phase_end && (phase_reg == `PHASE_ONE);
  wire enter_phase_three = phase_end && (phase_reg == `PHASE_TWO);
  wire enter_phase_four = phase_end && (phase_reg == `PHASE_THREE);
  // *****************************
  // input sequence
  // *****************************
  localparam ST_IDLE = 3'h0;
  localparam ST_C0_CLR = 3'h1;
  localparam ST_C0_LOAD = 3'h2;
  localparam ST_C0_WAIT = 3'h3;
  localparam ST_C0_ACK = 3'h4;
  localparam ST_C1_GATE = 3'h5;
  localparam ST_C1_CLR = 3'h6;
  localparam ST_C1_HOLD = 3'h7;
  reg [2:0] state_reg;
  reg [CNT_W-1:0] cnt_reg;
  wire is_input = instr_valid && (instr_word[`FUNC_MSB:`FUNC_LSB] == `FUNC_IO) &&
    (instr_word[`DESIG_MSB:`DESIG_LSB] == `DESIG_INPUT);
  wire ch0_sel = ~instr_word[`CHAN_SEL_BIT];
  always @(posedge ref_clk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      cnt_reg <= {CNT_W{1'b0}};
      in_data <= {WORD_WIDTH{1'b0}};
      func_reg <= 6'h00;
      operand_reg <= 9'h000;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (is_input) begin
            func_reg <= instr_word[`FUNC_MSB:`FUNC_LSB];
            operand_reg <= instr_word[`OPERAND_MSB:`OPERAND_LSB];
            state_reg <= ch0_sel ? ST_C0_CLR : ST_C1_GATE;
          end
        end
        ST_C0_CLR: begin
          if (enter_phase_two) begin
            in_data[LOW_SIX_WIDTH-1:0] <= {LOW_SIX_WIDTH{1'b0}};
            state_reg <= ST_C0_LOAD;
          end
        end
        ST_C0_LOAD: begin
          if (enter_phase_three) begin
            in_data[LOW_SIX_WIDTH-1:0] <= s_tty_data;
            cnt_reg <= {CNT_W{1'b0}};
            state_reg <= ST_C0_WAIT;
          end
        end
        ST_C0_WAIT: begin
          // ack would clear the typewriter's output register, so wait for the load
          if (cnt_reg == (`ACK_DELAY_CYCLES - 1)) begin
            cnt_reg <= {CNT_W{1'b0}};
            state_reg <= ST_C0_ACK;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        ST_C0_ACK: begin
          if (cnt_reg == (`CH0_ACK_CYCLES - 1)) begin
            state_reg <= ST_IDLE;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        ST_C1_GATE: begin
          if (enter_phase_four) begin
            in_data <= s_cable_data;
            state_reg <= ST_C1_CLR;
          end
        end
        ST_C1_CLR: begin
          // clear overlaps gating: set bits are re-asserted by the persisting input
          in_data <= s_cable_data;
          if (enter_phase_two) begin
            in_data <= {WORD_WIDTH{1'b0}} | s_cable_data;
            state_reg <= ST_C1_HOLD;
          end
        end
        ST_C1_HOLD: begin
          in_data <= s_cable_data;
          if (input_ack_flag) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
  // *****************************
  // acknowledge flag
  // *****************************
  wire ack_cmd = (state_reg == ST_C0_ACK) || (state_reg == ST_C1_GATE);
  always @(posedge ref_clk) begin
    if (srst) begin
      input_ack_flag <= 1'b1;
    end else if (ack_cmd) begin
      input_ack_flag <= 1'b0;
    end else if (!any_in_req && !s_intr) begin
      input_ack_flag <= 1'b1;
    end
  end
  assign ch0_in_ack = (state_reg == ST_C0_ACK);
  assign ch1_in_ack = (state_reg == ST_C1_HOLD) && !input_ack_flag;
  always @(posedge ref_clk) begin
    if (srst) begin
      busy <= 1'b0;
    end else begin
      busy <= (state_reg != ST_IDLE);
    end
  end
  // *****************************
  // jump evaluation
  // *****************************
  wire is_jump = instr_valid && jump_sample && (instr_word[`FUNC_MSB:`FUNC_LSB] == `FUNC_JUMP);
  wire [2:0] desig = instr_word[`DESIG_MSB:`DESIG_LSB];
  always @(posedge ref_clk) begin
    if (srst) begin
      jump_flag <= 1'b0;
    end else if (is_jump) begin
      case (desig)
        `DESIG_INPUT: jump_flag <= input_ack_flag && !any_in_req;
        `DESIG_OUTPUT: jump_flag <= output_ack_flag && !any_out_req;
        `DESIG_INTR: jump_flag <= input_ack_flag && !s_intr;
        default: jump_flag <= 1'b0;
      endcase
    end else begin
      jump_flag <= 1'b0;
    end
  end
endmodule

// *** verification/io_input_handshake_chk.sv ***
// assertions on the ports of the input handshake block
// assumes one ref_clk domain and a synchronous srst
`timescale 1ns/1ps
module io_input_handshake_chk #(
  parameter WORD_WIDTH = 15
) (
  input wire ref_clk,
  input wire srst,
  input wire instr_valid,
  input wire [WORD_WIDTH-1:0] instr_word,
  input wire jump_sample,
  input wire ch0_in_req,
  input wire ch1_in_req,
  input wire ch0_out_req,
  input wire ch1_out_req,
  input wire interrupt_line,
  input wire output_ack_flag,
  input wire ch0_in_ack,
  input wire ch1_in_ack,
  input wire jump_flag,
  input wire input_ack_flag
);
  // ****
  // helpers
  // ****
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  wire smp = instr_valid && jump_sample && instr_word[14:9] == 6'h0e;
  wire jin = smp && instr_word[8:6] == 3'h0;
  wire jout = smp && instr_word[8:6] == 3'h1;
  wire jint = smp && instr_word[8:6] == 3'h2;
  wire ireq = ch0_in_req || ch1_in_req;
  wire oreq = ch0_out_req || ch1_out_req;
  reg [9:0] len_reg;
  // counts high cycles, so a fall sees the whole length
  always @(posedge ref_clk) begin
    len_reg <= (srst || !ch0_in_ack) ? 10'h0 : len_reg + 10'h1;
  end
  // ****
  // rules
  // ****
  // lines are held eight cycles so the synchronisers have settled
  AST_CH0_LEN: assert property ($fell(ch0_in_ack) |-> len_reg == 10'h190)
    else $error("ch0 ack length wrong");
  AST_JF_PULSE: assert property (jump_flag |=> !jump_flag)
    else $error("jump flag stuck");
  AST_IN_IDLE: assert property ((!ireq && input_ack_flag)[*8] ##0 jin |-> ##[1:2] jump_flag)
    else $error("idle input jump missed");
  AST_IN_REQ: assert property (ireq[*8] ##0 jin |-> ##1 !jump_flag ##1 !jump_flag)
    else $error("input jump taken with request");
  AST_OUT: assert property ((!oreq && output_ack_flag)[*8] ##0 jout |-> ##[1:2] jump_flag)
    else $error("output jump missed");
  AST_INT: assert property (interrupt_line[*8] ##0 jint |-> ##1 !jump_flag ##1 !jump_flag)
    else $error("interrupt jump taken");
  AST_CH1_HOLD: assert property (ch1_in_ack && ch1_in_req |=> ch1_in_ack)
    else $error("ch1 ack dropped early");
  AST_CH1_END: assert property ($fell(ch1_in_ack) |-> !ch1_in_req && !interrupt_line && input_ack_flag)
    else $error("ch1 ack end wrong");
  cover property ($fell(ch0_in_ack));
  cover property ($fell(ch1_in_ack));
  cover property (jint ##1 jump_flag);
endmodule
bind io_input_handshake io_input_handshake_chk #(.WORD_WIDTH(WORD_WIDTH)) u_chk (.*);

// *** verification/cable_peripheral.sv ***
// behavioural channel 1 equipment on the input cable
// assumes start is a one-cycle pulse from the bench on ref_clk
`timescale 1ns/1ps
module cable_peripheral (
  input wire ref_clk,
  input wire start,
  input wire intr_mode,
  input wire [14:0] word,
  input wire [3:0] dly,
  input wire ack,
  output reg req,
  output reg intr,
  output reg [14:0] cable
);
  reg arm, held;
  reg [3:0] cnt;
  initial begin
    {req, intr, arm, held, cnt} = 8'h00;
    cable = 15'h2aaa;
  end
  // the word stays until the ack has gone, since the gate tracks it
  always @(posedge ref_clk) begin
    held <= ack;
    if (start) begin
      cable <= word;
      arm <= 1'b1;
    end else if (arm) begin
      arm <= 1'b0;
      req <= !intr_mode;
      intr <= intr_mode;
    end else if (ack && (req || intr)) begin
      cnt <= cnt + 4'h1;
      if (cnt == dly) begin
        req <= 1'b0;
        intr <= 1'b0;
        cnt <= 4'h0;
      end
    end else if (held && !ack) begin
      cable <= ~cable; // released lines do not keep the word
    end
  end
endmodule

// *** verification/testbench.sv ***
// self-checking bench for the input handshake and jump block
// assumes the design, checker and cable model are compiled first
`timescale 1ns/1ps
`include "io_input_defines.vh"
module testbench;
  reg ref_clk, srst, instr_valid, jump_sample, ch0_in_req, ch0_out_req, ch1_out_req, start, intr_mode, out_ack;
  reg [14:0] instr_word, cable_word;
  reg [5:0] tty_data;
  reg [3:0] dly;
  wire ch1_in_req, interrupt_line, ch0_in_ack, ch1_in_ack, jump_flag, input_ack_flag, busy;
  wire [14:0] cable_data, in_data;
  wire [5:0] func_reg;
  wire [8:0] operand_reg;
  integer err_total, n_checks, seed, n, i;
  logic got;
  logic [14:0] exp_q[$];
  initial begin
    ref_clk = 0;
    forever #2 ref_clk = ~ref_clk;
  end
  io_input_handshake DUT (.ref_clk(ref_clk), .srst(srst), .instr_valid(instr_valid), .instr_word(instr_word),
    .jump_sample(jump_sample), .tty_data(tty_data), .cable_data(cable_data), .ch0_in_req(ch0_in_req),
    .ch1_in_req(ch1_in_req), .ch0_out_req(ch0_out_req), .ch1_out_req(ch1_out_req),
    .interrupt_line(interrupt_line), .output_ack_flag(out_ack), .ch0_in_ack(ch0_in_ack), .ch1_in_ack(ch1_in_ack),
    .in_data(in_data), .jump_flag(jump_flag), .input_ack_flag(input_ack_flag), .func_reg(func_reg),
    .operand_reg(operand_reg), .busy(busy));
  cable_peripheral peer (.ref_clk(ref_clk), .start(start), .intr_mode(intr_mode), .word(cable_word), .dly(dly),
    .ack(ch1_in_ack), .req(ch1_in_req), .intr(interrupt_line), .cable(cable_data));
  // ****
  // tasks
  // ****
  task chk(input logic [14:0] seen, input logic [14:0] want);
    begin
      n_checks = n_checks + 1;
      if (seen !== want) begin
        err_total = err_total + 1;
        $display("BAD t=%0t seen %h want %h", $time, seen, want);
      end
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
        $display("SIMULATION PASSED");
      end else begin
        $display("SIMULATION FAILED");
      end
      $finish;
    end
  endtask
  // bounded wait on one acknowledge, n counts the cycles
  task wait_ack(input logic sel, input logic lvl);
    begin
      n = 0;
      while ((sel ? ch1_in_ack : ch0_in_ack) !== lvl) begin
        @(negedge ref_clk);
        n = n + 1;
        if (n > 2000) begin
          err_total = err_total + 1;
          stop_test;
        end
      end
    end
  endtask
  // the flag pulse may land one or two edges after the sample
  task jmp(input logic [2:0] d, input logic want);
    begin
      @(negedge ref_clk);
      instr_word = {`FUNC_JUMP, d, 6'h00};
      {instr_valid, jump_sample} = 2'h3;
      @(negedge ref_clk);
      {instr_valid, jump_sample} = 2'h0;
      got = jump_flag;
      @(negedge ref_clk);
      chk(got | jump_flag, want);
    end
  endtask
  task inp(input logic ch);
    begin
      @(negedge ref_clk);
      instr_word = {`FUNC_IO, 8'h00, ch};
      instr_valid = 1;
      @(negedge ref_clk);
      instr_valid = 0;
      @(negedge ref_clk);
      chk({func_reg, operand_reg}, {`FUNC_IO, 8'h00, ch});
      chk(busy, 1);
    end
  endtask
  // ****
  // sequence
  // ****
  initial begin
    seed = 32'h4910bc38;
    {err_total, n_checks} = 0;
    {srst, instr_valid, jump_sample, ch0_in_req, ch0_out_req, ch1_out_req, start, intr_mode} = 8'h80;
    {instr_word, cable_word, tty_data, dly} = 0;
    out_ack = 1;
    repeat (2) @(negedge ref_clk);
    srst = 0;
    chk(input_ack_flag, 1);
    repeat (8) @(negedge ref_clk);
    for (i = 0; i < 3; i = i + 1) jmp(i[2:0], 1);
    n = $random(seed);
    {ch0_out_req, ch1_out_req, ch0_in_req} = {n[0], !n[0], 1'b1};
    repeat (8) @(negedge ref_clk);
    jmp(0, 0);
    jmp(1, 0);
    jmp(2, 1);
    {ch0_out_req, ch1_out_req, ch0_in_req} = 3'h0;
    out_ack = 0;
    jmp(1, 0);
    out_ack = 1;
    $display("jump tests done");
    for (i = 0; i < 2; i = i + 1) begin
      @(negedge ref_clk);
      n = $random(seed);
      {cable_word, dly} = n[18:0];
      intr_mode = i[0];
      exp_q.push_back(cable_word);
      start = 1;
      @(negedge ref_clk);
      start = 0;
      repeat (8) @(negedge ref_clk);
      jmp({i[0], 2'h0} >> 1, 0);
      inp(1);
      wait_ack(1, 1);
      wait_ack(1, 0);
      chk(in_data, exp_q.pop_front());
      chk(input_ack_flag, 1);
      repeat (8) @(negedge ref_clk);
      jmp({i[0], 2'h0} >> 1, 1);
      chk(busy, 0);
      $display("channel 1 test %0d done", i);
    end
    n = $random(seed);
    tty_data = n[5:0];
    ch0_in_req = 1;
    repeat (8) @(negedge ref_clk);
    inp(0);
    wait_ack(0, 1);
    chk(n >= 500, 1);
    chk(n <= `ACK_DELAY_CYCLES + 5 * `PHASE_CYCLES, 1);
    chk(in_data, {cable_word[14:6], tty_data});
    jmp(0, 0);
    ch0_in_req = 0;
    wait_ack(0, 0);
    repeat (8) @(negedge ref_clk);
    jmp(0, 1);
    $display("channel 0 test done");
    stop_test;
  end
endmodule
